//--- verilog/fpf_pkg.sv
package fpf_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int DEPTH = 512;
    localparam int PTR_W = 9;
    localparam int CNT_W = 10;
    localparam int DATA_W = 18;
    localparam int OFF_W = 10;
    localparam int ADDR_W = 8;
    localparam int BUS_W = 32;

    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_EMPTY_OFF = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_FULL_OFF = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam int ST_COUNT_LSB = 0;
    localparam int ST_SYNC_BIT = 16;
    localparam int ST_FIRST_WORD_FALL_THROUGH_BIT = 17;
    localparam int ST_SERIAL_BIT = 18;
    localparam int ST_AE_BIT = 20;
    localparam int ST_AF_BIT = 21;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [OFF_W-1:0] DEF_EMPTY_OFF = 10'h07F;
    localparam logic [OFF_W-1:0] DEF_FULL_OFF = 10'h07F;
    localparam logic [BUS_W-1:0] RDATA_RST = 32'h00000000;

    // reset sequencing, gray along run -> master -> partial
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_MRS = 2'b01,
        ST_PRS = 2'b11
    } fpf_state_t;

endpackage

//--- verilog/fpf_sync2.sv
`timescale 1ns/1ps
module fpf_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // first stage is read by the second stage only
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

//--- verilog/fpf_top.sv
`timescale 1ns/1ps
module fpf_top (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic master_reset_n_i,
    input wire logic partial_reset_n_i,
    input wire logic flag_timing_select_i,
    input wire logic first_word_fall_through_i,
    input wire logic serial_program_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [fpf_pkg::DATA_W-1:0] mem_data_i,
    input wire logic [fpf_pkg::ADDR_W-1:0] addr_i,
    input wire logic [fpf_pkg::BUS_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [fpf_pkg::BUS_W-1:0] rdata_o,
    output logic almost_empty_flag_o,
    output logic almost_full_flag_o,
    output logic [fpf_pkg::DATA_W-1:0] q_o,
    output logic [fpf_pkg::PTR_W-1:0] wr_addr_o,
    output logic [fpf_pkg::PTR_W-1:0] rd_addr_o
);
    import fpf_pkg::*;

    // ------------------------------------------------------------
    // flag decode, shared by both timing modes
    // ------------------------------------------------------------
    function automatic logic fpf_ae(input logic [CNT_W-1:0] cnt, input logic [OFF_W-1:0] off);
        fpf_ae = (cnt >= off);
    endfunction

    function automatic logic fpf_af(input logic [CNT_W-1:0] cnt, input logic [OFF_W-1:0] off);
        logic [CNT_W-1:0] free;
        free = CNT_W'(DEPTH) - cnt;
        fpf_af = (free > off);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic mrs_n_s;
    logic prs_n_s;
    logic sel_s;
    logic first_word_fall_through_s;
    logic serial_s;

    fpf_sync2 #(
        .WIDTH(5),
        .RST_VAL(5'h03)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i({serial_program_i, first_word_fall_through_i, flag_timing_select_i,
              partial_reset_n_i, master_reset_n_i}),
        .q_o({serial_s, first_word_fall_through_s, sel_s, prs_n_s, mrs_n_s})
    );

    // ------------------------------------------------------------
    // reset sequencing
    // ------------------------------------------------------------
    fpf_state_t state;

    // master reset outranks partial reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= ST_RUN;
        end else if (!mrs_n_s) begin
            state <= ST_MRS;
        end else if (!prs_n_s) begin
            state <= ST_PRS;
        end else begin
            state <= ST_RUN;
        end
    end

    logic in_reset;
    assign in_reset = (state != ST_RUN);

    // ------------------------------------------------------------
    // configuration, kept through partial reset
    // ------------------------------------------------------------
    logic timing_sync;
    logic first_word_fall_through;
    logic serial_prog;
    logic [OFF_W-1:0] empty_off;
    logic [OFF_W-1:0] full_off;

    // selects are sampled on every master reset cycle, the last one included,
    // so a select that moves near the release edge may still be caught
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            timing_sync <= 1'b0;
            first_word_fall_through <= 1'b0;
            serial_prog <= 1'b0;
        end else if (state == ST_MRS) begin
            timing_sync <= sel_s;
            first_word_fall_through <= first_word_fall_through_s;
            serial_prog <= serial_s;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            empty_off <= DEF_EMPTY_OFF;
            full_off <= DEF_FULL_OFF;
        end else if (state == ST_MRS) begin
            empty_off <= DEF_EMPTY_OFF;
            full_off <= DEF_FULL_OFF;
        end else if (wr_i) begin
            // partial reset does not touch the offsets
            if (addr_i == ADDR_EMPTY_OFF) begin
                empty_off <= wdata_i[OFF_W-1:0];
            end
            if (addr_i == ADDR_FULL_OFF) begin
                full_off <= wdata_i[OFF_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // pointers and word count
    // ------------------------------------------------------------
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic do_wr;
    logic do_rd;

    assign do_wr = wr_en_i && !in_reset && (count != CNT_W'(DEPTH));
    assign do_rd = rd_en_i && !in_reset && (count != '0);

    always_comb begin
        next_count = count;
        if (do_wr && !do_rd) begin
            next_count = count + CNT_W'(1);
        end else if (do_rd && !do_wr) begin
            next_count = count - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || in_reset) begin
            wr_addr_o <= '0;
            rd_addr_o <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_addr_o <= wr_addr_o + PTR_W'(1);
            end
            if (do_rd) begin
                rd_addr_o <= rd_addr_o + PTR_W'(1);
            end
            count <= next_count;
        end
    end

    // output register takes the word addressed by the read pointer
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || in_reset) begin
            q_o <= '0;
        end else if (do_rd) begin
            q_o <= mem_data_i;
        end
    end

    // ------------------------------------------------------------
    // programmable flags
    // ------------------------------------------------------------
    // asynchronous timing follows the count in the same edge as the
    // pointer move; synchronous timing adds one registered stage,
    // costing a cycle of latency; both modes drive the flags from the same clocked register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            almost_empty_flag_o <= 1'b0;
            almost_full_flag_o <= 1'b1;
        end else if (timing_sync) begin
            almost_empty_flag_o <= fpf_ae(count, empty_off);
            almost_full_flag_o <= fpf_af(count, full_off);
        end else begin
            almost_empty_flag_o <= fpf_ae(next_count, empty_off);
            almost_full_flag_o <= fpf_af(next_count, full_off);
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= RDATA_RST;
        end else if (rd_i) begin
            case (addr_i)
                ADDR_EMPTY_OFF: begin
                    rdata_o <= BUS_W'(empty_off);
                end
                ADDR_FULL_OFF: begin
                    rdata_o <= BUS_W'(full_off);
                end
                ADDR_STATUS: begin
                    rdata_o <= RDATA_RST;
                    rdata_o[ST_COUNT_LSB +: CNT_W] <= count;
                    rdata_o[ST_SYNC_BIT] <= timing_sync;
                    rdata_o[ST_FIRST_WORD_FALL_THROUGH_BIT] <= first_word_fall_through;
                    rdata_o[ST_SERIAL_BIT] <= serial_prog;
                    rdata_o[ST_AE_BIT] <= almost_empty_flag_o;
                    rdata_o[ST_AF_BIT] <= almost_full_flag_o;
                end
                default: begin
                    rdata_o <= RDATA_RST;
                end
            endcase
        end else begin
            // data stand for one cycle only
            rdata_o <= RDATA_RST;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_prs_done;
        (state == ST_PRS) ##1 (state == ST_RUN);
    endsequence

    sequence s_mrs_step;
        (state == ST_MRS) && !wr_i;
    endsequence

    sequence s_mrs_done;
        (state == ST_MRS) ##1 (state == ST_RUN);
    endsequence

    AST_AE_ASYNC: assert property (!timing_sync && !wr_i && !in_reset |=>
        almost_empty_flag_o == (count >= $past(empty_off)))
        else $error("almost-empty flag wrong in asynchronous timing");
    AST_AF_ASYNC: assert property (!timing_sync && !wr_i && !in_reset |=>
        almost_full_flag_o == ((CNT_W'(DEPTH) - count) > $past(full_off)))
        else $error("almost-full flag wrong in asynchronous timing");
    AST_AE_SYNC: assert property (timing_sync && !wr_i ##1 timing_sync |->
        almost_empty_flag_o == ($past(count) >= $past(empty_off)))
        else $error("almost-empty flag not one cycle behind count");
    AST_AF_SYNC: assert property (timing_sync && !wr_i ##1 timing_sync |->
        almost_full_flag_o == ((CNT_W'(DEPTH) - $past(count)) > $past(full_off)))
        else $error("almost-full flag not one cycle behind count");
    AST_MRS_MODE: assert property ((state == ST_MRS) |=> timing_sync == $past(sel_s))
        else $error("flag timing select not latched in master reset");
    AST_MRS_DEFAULT: assert property (s_mrs_step |=>
        (empty_off == DEF_EMPTY_OFF) && (full_off == DEF_FULL_OFF) && (count == '0))
        else $error("master reset did not load default offsets");
    AST_PRS_CLEAR: assert property (s_prs_done |->
        (wr_addr_o == '0) && (rd_addr_o == '0) && (q_o == '0))
        else $error("partial reset left pointers or output set");
    AST_PRS_KEEP: assert property ((state == ST_PRS) && !wr_i |=>
        $stable(empty_off) && $stable(full_off) && $stable(timing_sync)
        && $stable(first_word_fall_through) && $stable(serial_prog))
        else $error("partial reset changed configuration");
    AST_STATUS_READ: assert property (rd_i && (addr_i == ADDR_STATUS) |=>
        rdata_o[ST_COUNT_LSB +: CNT_W] == $past(count))
        else $error("status read returned wrong count");

    // pointer moves refused while full or empty leave no trace
    AST_FULL_REFUSE: assert property ((count == CNT_W'(DEPTH)) && !in_reset |=>
        $stable(wr_addr_o))
        else $error("write taken while full");
    AST_EMPTY_REFUSE: assert property ((count == '0) && !in_reset |=>
        $stable(rd_addr_o) && $stable(q_o))
        else $error("read taken while empty");
    AST_NO_OVERFLOW: assert property (count <= CNT_W'(DEPTH))
        else $error("word count above depth");
    AST_PTR_GAP: assert property ((wr_addr_o - rd_addr_o) == count[PTR_W-1:0])
        else $error("pointer distance differs from word count");
    AST_MRS_CLEAR: assert property ((state == ST_MRS) |=>
        (wr_addr_o == '0) && (rd_addr_o == '0) && (q_o == '0))
        else $error("master reset left pointers or output set");
    AST_MRS_RELEASE: assert property (s_mrs_done |->
        (empty_off == DEF_EMPTY_OFF) && (full_off == DEF_FULL_OFF))
        else $error("offsets not at defaults when master reset ends");
    AST_PRS_COUNT: assert property ((state == ST_PRS) |=> (count == '0) && (q_o == '0))
        else $error("partial reset left words counted");
    AST_MODE_HOLD: assert property ((state == ST_RUN) |=>
        $stable(timing_sync) && $stable(first_word_fall_through) && $stable(serial_prog))
        else $error("mode changed outside master reset");
    AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == RDATA_RST)
        else $error("read data stood longer than one cycle");

endmodule

//--- verification/fpf_far_end.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// writing and reading logic with the external word array
// ------------------------------------------------------------
module fpf_far_end (
    input wire logic clk_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [fpf_pkg::PTR_W-1:0] wr_addr_i,
    input wire logic [fpf_pkg::PTR_W-1:0] rd_addr_i,
    output logic wr_en_o,
    output logic rd_en_o,
    output logic [fpf_pkg::DATA_W-1:0] mem_data_o
);
    import fpf_pkg::*;
    logic [DATA_W-1:0] mem [DEPTH];
    // unwritten words hold a pattern, so a stale read never passes for a zero
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = 18'h2AAAA;
        end
    end
    assign wr_en_o = push_i;
    assign rd_en_o = pop_i;
    always @(posedge clk_i) begin
        if (push_i) begin
            mem[wr_addr_i] <= {9'h0A5, wr_addr_i};
        end
    end
    assign mem_data_o = mem[rd_addr_i];
endmodule

//--- verification/test_fpf_top.sv
`timescale 1ns/1ps
module test_fpf_top;
    import fpf_pkg::*;
    logic clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic mrs_n = 1'h1;
    logic prs_n = 1'h1;
    logic flag_sel = 1'h0;
    logic first_word_fall_through = 1'h0;
    logic serial = 1'h0;
    logic push = 1'h0;
    logic pop = 1'h0;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [BUS_W-1:0] wdata = 32'h0;
    logic [BUS_W-1:0] rdata;
    logic [BUS_W-1:0] d;
    logic wr_en, rd_en, ae, af;
    logic [DATA_W-1:0] mem_data, q;
    logic [PTR_W-1:0] wa, ra;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;

    always #12.5 clk_i = ~clk_i;

    fpf_top fpf_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .master_reset_n_i(mrs_n),
        .partial_reset_n_i(prs_n), .flag_timing_select_i(flag_sel),
        .first_word_fall_through_i(first_word_fall_through), .serial_program_i(serial), .wr_en_i(wr_en),
        .rd_en_i(rd_en), .mem_data_i(mem_data), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .almost_empty_flag_o(ae), .almost_full_flag_o(af),
        .q_o(q), .wr_addr_o(wa), .rd_addr_o(ra));
    fpf_far_end fpf_far_end_inst (.clk_i(clk_i), .push_i(push), .pop_i(pop), .wr_addr_i(wa),
        .rd_addr_i(ra), .wr_en_o(wr_en), .rd_en_o(rd_en), .mem_data_o(mem_data));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [BUS_W-1:0] got, input logic [BUS_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [BUS_W-1:0] st(input logic [9:0] cnt, input logic s,
        input logic f, input logic p, input logic e, input logic a);
        logic [BUS_W-1:0] v;
        v = '0;
        v[9:0] = cnt;
        v[ST_SYNC_BIT] = s;
        v[ST_FIRST_WORD_FALL_THROUGH_BIT] = f;
        v[ST_SERIAL_BIT] = p;
        v[ST_AE_BIT] = e;
        v[ST_AF_BIT] = a;
        return v;
    endfunction

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] v);
        @(posedge clk_i);
        wr <= 1'h1;
        addr <= a;
        wdata <= v;
        @(posedge clk_i);
        wr <= 1'h0;
    endtask

    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [BUS_W-1:0] v);
        @(posedge clk_i);
        rd <= 1'h1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'h0;
        #1;
        v = rdata;
    endtask

    task automatic xfer(input logic w, input logic r);
        @(posedge clk_i);
        push <= w;
        pop <= r;
        @(posedge clk_i);
        push <= 1'h0;
        pop <= 1'h0;
        #1;
    endtask

    // selects change only while master reset is held, then stay put
    task automatic pin_reset(input logic master, input logic [2:0] mode);
        @(posedge clk_i);
        if (master) begin
            {flag_sel, first_word_fall_through, serial} <= mode;
            mrs_n <= 1'h0;
        end else begin
            prs_n <= 1'h0;
        end
        repeat (6) @(posedge clk_i);
        mrs_n <= 1'h1;
        prs_n <= 1'h1;
        repeat (6) @(posedge clk_i);
    endtask

    // ------------------------------------------------------------
    // hang guard, the whole sequence needs about 1130 cycles
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'h1;
        reg_rd(ADDR_EMPTY_OFF, d);
        chk(d, 32'h7F);
        reg_rd(8'h0C, d);
        chk(d, 32'h0);
        pin_reset(1'h1, 3'h3);
        reg_rd(ADDR_STATUS, d);
        chk(d, st(10'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1));
        reg_wr(ADDR_EMPTY_OFF, 32'h3);
        reg_wr(ADDR_FULL_OFF, 32'h1FD);
        for (int i = 1; i <= 4; i++) begin
            xfer(1'h1, 1'h0);
            chk(ae, i >= 3);
            chk(af, (512 - i) > 509);
        end
        xfer(1'h0, 1'h1);
        chk(q, {9'h0A5, 9'h000});
        xfer(1'h0, 1'h1);
        chk(ae, 1'h0);
        pin_reset(1'h0, 3'h0);
        chk({wa, ra}, 18'h0);
        chk(q, 18'h0);
        reg_rd(ADDR_STATUS, d);
        chk(d, st(10'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1));
        reg_rd(ADDR_EMPTY_OFF, d);
        chk(d, 32'h3);
        reg_rd(ADDR_FULL_OFF, d);
        chk(d, 32'h1FD);
        pin_reset(1'h1, 3'h4);
        reg_rd(ADDR_STATUS, d);
        chk(d, st(10'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1));
        reg_rd(ADDR_FULL_OFF, d);
        chk(d, 32'h7F);
        reg_wr(ADDR_EMPTY_OFF, 32'h1);
        xfer(1'h1, 1'h0);
        chk(ae, 1'h0);
        @(posedge clk_i);
        #1;
        chk(ae, 1'h1);
        repeat (512) xfer(1'h1, 1'h0);
        reg_rd(ADDR_STATUS, d);
        chk(d, st(10'h200, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0));
        xfer(1'h0, 1'h1);
        chk(ra, 9'h001);
        pin_reset(1'h0, 3'h0);
        xfer(1'h0, 1'h1);
        chk({wa, ra}, 18'h0);
        chk(q, 18'h0);
        reg_rd(ADDR_STATUS, d);
        chk(d, st(10'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1));
        give_verdict();
    end
endmodule
